/* hw/usf_pkg.sv */
// Purpose: Constants for the undervoltage, soft start and filter registers.
// Assumes: One 200 MHz core clock and byte-wide registers.
// Notes: Offsets are byte addresses on the plain register port.
// Notes on behaviour
// R1: Debounce bit selects none or 100 ms.
// R2: Flag set when threshold exceeds voltage MSBs.
// R3: Threshold step equals 12.5 mV.
// R4: Zero threshold keeps flag always cleared.
// R5: Channel A ramp time from two-bit code.
// R6: Channel B ramp time, same four codes.
// R7: Ramp times refer to two-thirds span target.
// R8: Channel A low frequency gain, 0.3 dB steps.
// R9: Channel B low frequency gain, 0.3 dB steps.
// R10: Per-channel eight-bit filter zero position settings.
// R11: Upper six soft start bits are ignored.
// R12: Debounced flag needs continuous true comparison.
package usf_pkg;

  // Bus and data widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int TIME_W = 16;
  localparam int THR_W  = 14;

  // Register byte addresses.
  localparam logic [15:0] OFS_UV_B_SET   = 16'hfe29;
  localparam logic [15:0] OFS_SS_A       = 16'hfe2a;
  localparam logic [15:0] OFS_SS_B       = 16'hfe2b;
  localparam logic [15:0] OFS_LF_GAIN_A  = 16'hfe2c;
  localparam logic [15:0] OFS_LF_GAIN_B  = 16'hfe2d;
  localparam logic [15:0] OFS_ZERO_A     = 16'hfe2e;
  localparam logic [15:0] OFS_ZERO_B     = 16'hfe2f;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'hfe80;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'hfe81;
  localparam logic [15:0] OFS_LIVE       = 16'hfe82;

  // Field positions.
  localparam int UV_DEB_BIT   = 7;
  localparam int UV_THR_MSB   = 6;
  localparam int SS_SEL_MSB   = 1;
  localparam int EV_RISE_BIT  = 0;
  localparam int EV_FALL_BIT  = 1;
  localparam int LIVE_FLAG_BIT = 0;
  localparam int LIVE_CMP_BIT  = 1;

  // Reset value and event bit mask.
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] EV_MASK = 2'h3;

  // Threshold step in tenths of a millivolt (12.5 mV).
  localparam logic [6:0] UV_STEP_TENTH_MV = 7'h7d;

  // Soft start ramp times in microseconds for codes 00, 01, 10, 11.
  localparam logic [15:0] RAMP_US_0 = 16'h06d6;
  localparam logic [15:0] RAMP_US_1 = 16'h2904;
  localparam logic [15:0] RAMP_US_2 = 16'h5208;
  localparam logic [15:0] RAMP_US_3 = 16'h9d08;

  // Debounce time and its cycle count at the core clock rate.
  localparam int DEBOUNCE_MS     = 100;
  localparam int CLK_KHZ         = 200000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

endpackage : usf_pkg

/* hw/usf_regs.sv */
// Purpose: Register bank for channel B undervoltage, soft start and filters.
// Assumes: Sensed voltage comes from logic on the same core clock.
// Notes: Read data appear in the cycle after the read strobe only.
`timescale 1ns/1ps
`default_nettype none
module usf_regs
#(
  parameter int unsigned DEBOUNCE_CYCLES = usf_pkg::DEBOUNCE_CYCLES
)
(
  input  wire logic                            CORE_CLK,
  input  wire logic                            RST_N,
  input  wire logic [usf_pkg::ADDR_W-1:0]      ADDR,
  input  wire logic [usf_pkg::DATA_W-1:0]      WDATA,
  input  wire logic                            WR_STB,
  input  wire logic                            RD_STB,
  output logic      [usf_pkg::DATA_W-1:0]      RDATA,
  input  wire logic [usf_pkg::DATA_W-1:0]      CHAN_B_SENSED_VOLTAGE,
  output logic                                 CHAN_B_UNDERVOLT_FLAG,
  output logic      [usf_pkg::THR_W-1:0]       CHAN_B_UV_THRESHOLD,
  output logic      [1:0]                      CHAN_A_RAMP_SEL,
  output logic      [1:0]                      CHAN_B_RAMP_SEL,
  output logic      [usf_pkg::TIME_W-1:0]      CHAN_A_RAMP_TIME_US,
  output logic      [usf_pkg::TIME_W-1:0]      CHAN_B_RAMP_TIME_US,
  output logic      [usf_pkg::DATA_W-1:0]      CHAN_A_LF_GAIN,
  output logic      [usf_pkg::DATA_W-1:0]      CHAN_B_LF_GAIN,
  output logic      [usf_pkg::DATA_W-1:0]      CHAN_A_ZERO_POS,
  output logic      [usf_pkg::DATA_W-1:0]      CHAN_B_ZERO_POS,
  output logic                                 IRQ
);
  import usf_pkg::*;

  // Last count value of the debounce interval, at counter width.
  // Thirty-two bits cover the full 100 ms count at the core clock rate.
  localparam logic [31:0] DEB_LAST =
    (DEBOUNCE_CYCLES > 0) ? 32'(DEBOUNCE_CYCLES - 1) : 32'h0;

  // Stored register contents.
  logic [DATA_W-1:0] uv_b_set;      // Debounce bit and threshold.
  logic [DATA_W-1:0] ss_a;          // Channel A soft start.
  logic [DATA_W-1:0] ss_b;          // Channel B soft start.
  logic [DATA_W-1:0] lf_gain_a;     // Channel A low frequency gain.
  logic [DATA_W-1:0] lf_gain_b;     // Channel B low frequency gain.
  logic [DATA_W-1:0] zero_a;        // Channel A zero position.
  logic [DATA_W-1:0] zero_b;        // Channel B zero position.
  logic [1:0]        irq_status;    // Sticky flag edge events.
  logic [1:0]        irq_mask;      // Enables for the events.

  // Undervoltage detection state.
  logic [6:0]        uv_thr;        // Threshold field.
  logic              uv_deb_en;     // Debounce selection.
  logic              uv_cmp;        // Raw comparison result.
  logic [31:0]       deb_cnt;       // Cycles the comparison has held.
  logic              next_flag;     // Flag value for the next edge.
  logic              flag_d;        // Flag one cycle ago for edges.
  logic [1:0]        ev_set;        // Event pulses this cycle.
  logic [1:0]        ev_clr;        // Write-one-to-clear pulses.
  logic [1:0]        next_status;   // Status value after this edge.
  logic [1:0]        next_mask;     // Mask value after this edge.
  logic [DATA_W-1:0] next_rdata;    // Read mux result.

  // Ramp code lookup; codes beyond two bits cannot reach here.
  function automatic logic [TIME_W-1:0] ramp_us(input logic [1:0] sel);
    logic [TIME_W-1:0] t;
    t = RAMP_US_0;
    case (sel)
      2'h0:    t = RAMP_US_0;
      2'h1:    t = RAMP_US_1;
      2'h2:    t = RAMP_US_2;
      2'h3:    t = RAMP_US_3;
      default: t = RAMP_US_0;
    endcase
    return t;
  endfunction : ramp_us

  assign uv_thr    = uv_b_set[UV_THR_MSB:0];
  assign uv_deb_en = uv_b_set[UV_DEB_BIT];

  // Comparison against the seven upper voltage bits; zero disables it.
  // A zero threshold can never exceed the voltage anyway, but the
  // explicit term keeps the intent visible.
  always_comb
  begin
    uv_cmp = (uv_thr != 7'h00) && // R4
             (uv_thr > CHAN_B_SENSED_VOLTAGE[DATA_W-1:1]); // R2
  end

  // Debounce counter runs only while the comparison holds.
  // Any break in the comparison restarts the interval from zero.
  // It stops at the last count, so a long undervoltage never wraps it.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      deb_cnt <= 32'h0;
    end
    else if (!uv_cmp)
    begin
      deb_cnt <= 32'h0; // R12
    end
    else if (deb_cnt < DEB_LAST)
    begin
      deb_cnt <= deb_cnt + 32'h1; // R12
    end
  end

  // Next flag value: immediate without debounce, delayed with it.
  // Only the rising side is debounced; the flag drops once it fails.
  always_comb
  begin
    if (!uv_cmp)
    begin
      next_flag = 1'b0; // R4
    end
    else if (!uv_deb_en)
    begin
      next_flag = 1'b1; // R1
    end
    else
    begin
      next_flag = (deb_cnt >= DEB_LAST); // R1 R12
    end
  end

  // Flag register and its delayed copy for edge events.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CHAN_B_UNDERVOLT_FLAG <= 1'b0;
      flag_d                <= 1'b0;
    end
    else
    begin
      CHAN_B_UNDERVOLT_FLAG <= next_flag; // R2
      flag_d                <= CHAN_B_UNDERVOLT_FLAG;
    end
  end

  // Events from the registered flag edges.
  assign ev_set[EV_RISE_BIT] = CHAN_B_UNDERVOLT_FLAG & ~flag_d;
  assign ev_set[EV_FALL_BIT] = ~CHAN_B_UNDERVOLT_FLAG & flag_d;

  // Clear pulses from a status write with ones in the bits.
  assign ev_clr = (WR_STB && (ADDR == OFS_IRQ_STATUS)) ? WDATA[1:0] : 2'h0;

  // Status after this edge; a set in the clear cycle wins, so an event
  // that fires just as software clears its bit is never lost.
  always_comb
  begin
    next_status = (irq_status & ~ev_clr) | ev_set;
  end

  // Mask after this edge, so the interrupt follows a mask write in the
  // same cycle as the mask register itself does.
  always_comb
  begin
    next_mask = irq_mask;
    if (WR_STB && (ADDR == OFS_IRQ_MASK))
    begin
      next_mask = WDATA[1:0] & EV_MASK;
    end
  end

  // Sticky status register.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      irq_status <= 2'h0;
    end
    else
    begin
      irq_status <= next_status;
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  // Built from the next status and mask, so it never lags either one.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(next_status & next_mask);
    end
  end

  // Software writes; unmapped addresses are ignored.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      uv_b_set  <= RST_REG;
      ss_a      <= RST_REG;
      ss_b      <= RST_REG;
      lf_gain_a <= RST_REG;
      lf_gain_b <= RST_REG;
      zero_a    <= RST_REG;
      zero_b    <= RST_REG;
      irq_mask  <= 2'h0;
    end
    else if (WR_STB)
    begin
      case (ADDR)
        OFS_UV_B_SET:  uv_b_set  <= WDATA; // R1 R2
        OFS_SS_A:      ss_a      <= WDATA; // R5
        OFS_SS_B:      ss_b      <= WDATA; // R6
        OFS_LF_GAIN_A: lf_gain_a <= WDATA; // R8
        OFS_LF_GAIN_B: lf_gain_b <= WDATA; // R9
        OFS_ZERO_A:    zero_a    <= WDATA; // R10
        OFS_ZERO_B:    zero_b    <= WDATA; // R10
        OFS_IRQ_MASK:  irq_mask  <= next_mask;
        default:       irq_mask  <= irq_mask;
      endcase
    end
  end

  // Read mux; reserved soft start bits read back as written.
  // Unmapped addresses read as zero, so software may probe freely.
  always_comb
  begin
    case (ADDR)
      OFS_UV_B_SET:   next_rdata = uv_b_set;
      OFS_SS_A:       next_rdata = ss_a;
      OFS_SS_B:       next_rdata = ss_b;
      OFS_LF_GAIN_A:  next_rdata = lf_gain_a;
      OFS_LF_GAIN_B:  next_rdata = lf_gain_b;
      OFS_ZERO_A:     next_rdata = zero_a;
      OFS_ZERO_B:     next_rdata = zero_b;
      OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
      OFS_IRQ_MASK:   next_rdata = {6'h00, irq_mask};
      OFS_LIVE:       next_rdata = {6'h00, uv_cmp, CHAN_B_UNDERVOLT_FLAG};
      default:        next_rdata = 8'h00;
    endcase
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      RDATA <= 8'h00;
    end
    else if (RD_STB)
    begin
      RDATA <= next_rdata;
    end
    else
    begin
      RDATA <= 8'h00;
    end
  end

  // Soft start outputs; only the two low bits reach the sequencer.
  // The reserved upper bits are kept for read-back and never used here.
  // Ramp times are for a target of two thirds of the full scale span;
  // the sequencer scales them for other targets.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CHAN_A_RAMP_SEL     <= 2'h0;
      CHAN_B_RAMP_SEL     <= 2'h0;
      CHAN_A_RAMP_TIME_US <= RAMP_US_0;
      CHAN_B_RAMP_TIME_US <= RAMP_US_0;
    end
    else
    begin
      CHAN_A_RAMP_SEL     <= ss_a[SS_SEL_MSB:0]; // R5 R11
      CHAN_B_RAMP_SEL     <= ss_b[SS_SEL_MSB:0]; // R6 R11
      CHAN_A_RAMP_TIME_US <= ramp_us(ss_a[SS_SEL_MSB:0]); // R5 R7
      CHAN_B_RAMP_TIME_US <= ramp_us(ss_b[SS_SEL_MSB:0]); // R6 R7
    end
  end

  // Filter settings and the threshold in tenths of a millivolt.
  // The gain codes are passed raw; the filter maps them to dB.
  // The threshold product is at most 127 times 125, which fits 14 bits.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CHAN_A_LF_GAIN      <= RST_REG;
      CHAN_B_LF_GAIN      <= RST_REG;
      CHAN_A_ZERO_POS     <= RST_REG;
      CHAN_B_ZERO_POS     <= RST_REG;
      CHAN_B_UV_THRESHOLD <= 14'h0000;
    end
    else
    begin
      CHAN_A_LF_GAIN      <= lf_gain_a; // R8
      CHAN_B_LF_GAIN      <= lf_gain_b; // R9
      CHAN_A_ZERO_POS     <= zero_a; // R10
      CHAN_B_ZERO_POS     <= zero_b; // R10
      CHAN_B_UV_THRESHOLD <= 14'(uv_thr * UV_STEP_TENTH_MV); // R3
    end
  end

endmodule : usf_regs
`default_nettype wire

/* sim/usf_regs_bench.sv */
// Purpose: Self-checking bench for the usf register bank.
// Assumes: Debounce is cut to DEB cycles to keep the run short.
// Notes: Array m holds the expected register images.
`timescale 1ns/1ps
`default_nettype none
module usf_regs_bench;
  import usf_pkg::*;
  localparam int DEB = 8; // Short debounce count.
  logic        clk, rst_n, wr, rd, flag, irq;
  logic [15:0] addr, ta, tb;
  logic [7:0]  wd, rdat, volt, ga, gb, za, zb;
  logic [13:0] thr;
  logic [1:0]  sa, sb;
  logic [7:0]  m [7];   // Expected register images.
  logic [15:0] ofs [7]; // Register addresses in table order.
  logic [15:0] rt [4];  // Ramp times in microseconds.
  int          bad_count, n_checks, cyc;

  usf_regs #(.DEBOUNCE_CYCLES(DEB)) u_usf_regs (
    .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wd),
    .WR_STB(wr), .RD_STB(rd), .RDATA(rdat),
    .CHAN_B_SENSED_VOLTAGE(volt), .CHAN_B_UNDERVOLT_FLAG(flag),
    .CHAN_B_UV_THRESHOLD(thr), .CHAN_A_RAMP_SEL(sa),
    .CHAN_B_RAMP_SEL(sb), .CHAN_A_RAMP_TIME_US(ta),
    .CHAN_B_RAMP_TIME_US(tb), .CHAN_A_LF_GAIN(ga), .CHAN_B_LF_GAIN(gb),
    .CHAN_A_ZERO_POS(za), .CHAN_B_ZERO_POS(zb), .IRQ(irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One access; an idle cycle follows so no strobe is set twice at once.
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d, e);
    wr   <= w;
    rd   <= !w;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    if (!w) chk("rdata", rdat, e);
    @(posedge clk);
  endtask : bus

  task automatic fchk(input int n, input logic ef, ei);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk("flag", flag, ef);
    chk("irq", irq, ei);
    @(posedge clk);
  endtask : fchk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Guards against a hang; the whole run needs well under this.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    ofs = '{OFS_UV_B_SET, OFS_SS_A, OFS_SS_B, OFS_LF_GAIN_A,
            OFS_LF_GAIN_B, OFS_ZERO_A, OFS_ZERO_B};
    rt = '{16'h06d6, 16'h2904, 16'h5208, 16'h9d08};
    void'($urandom(32'h5ed3));
    {rst_n, wr, rd, addr, wd, volt} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[k]) bus(0, ofs[k], 0, 0);
    volt <= 8'hff; // Top voltage keeps the comparison false.
    for (int i = 0; i < 4; i++)
    begin
      foreach (ofs[k])
      begin
        m[k] = 8'($urandom);
        if (k == 0) m[k][7] = 1'b0;
        if (k == 1 || k == 2) m[k][1:0] = 2'(i);
        bus(1, ofs[k], m[k], 0);
      end
      foreach (ofs[k]) bus(0, ofs[k], 0, m[k]);
      @(negedge clk);
      chk("thr", thr, {7'h00, m[0][6:0]} * 14'h7d);
      chk("sel_a", sa, m[1][1:0]);
      chk("time_a", ta, rt[m[1][1:0]]);
      chk("sel_b", sb, m[2][1:0]);
      chk("time_b", tb, rt[m[2][1:0]]);
      chk("gain_a", ga, m[3]);
      chk("gain_b", gb, m[4]);
      chk("zero_a", za, m[5]);
      chk("zero_b", zb, m[6]);
      @(posedge clk);
    end
    bus(1, 16'hfe30, 8'h5a, 0);
    bus(0, 16'hfe30, 0, 0);
    bus(1, OFS_IRQ_MASK, 8'h03, 0);
    bus(1, OFS_UV_B_SET, 8'h40, 0);
    volt <= 8'h7f; // One step under the threshold.
    fchk(1, 1, 0);
    fchk(0, 1, 1);
    bus(0, OFS_IRQ_STATUS, 0, 8'h01);
    bus(1, OFS_IRQ_STATUS, 8'h01, 0);
    fchk(0, 1, 0);
    volt <= 8'h81; // Equal to the threshold, so no undervoltage.
    fchk(1, 0, 0);
    fchk(0, 0, 1);
    bus(0, OFS_IRQ_STATUS, 0, 8'h02);
    bus(1, OFS_IRQ_STATUS, 8'h03, 0);
    bus(1, OFS_UV_B_SET, 8'hc0, 0);
    volt <= 8'h7f;
    repeat (DEB - 1) @(posedge clk);
    volt <= 8'h81; // The run breaks one cycle short.
    fchk(1, 0, 0);
    volt <= 8'h7f;
    fchk(DEB - 1, 0, 0);
    fchk(0, 1, 0);
    bus(0, OFS_LIVE, 0, 8'h03);
    bus(1, OFS_UV_B_SET, 8'h00, 0);
    volt <= 8'h00;
    fchk(3, 0, 1);
    bus(1, OFS_IRQ_MASK, 8'h01, 0);
    bus(1, OFS_IRQ_STATUS, 8'h01, 0);
    fchk(0, 0, 0);
    bus(0, OFS_IRQ_MASK, 0, 8'h01);
    bus(0, OFS_IRQ_STATUS, 0, 8'h02);
    bus(1, OFS_IRQ_MASK, 8'h03, 0);
    fchk(0, 0, 1);
    rst_n <= 1'b0; // A mid-run reset must restore both ramp times, gain A and the interrupt.
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("rst_time_a", ta, RAMP_US_0);
    chk("rst_time_b", tb, RAMP_US_0);
    chk("rst_gain_a", ga, 0);
    chk("rst_irq", irq, 0);
    @(posedge clk);
    bus(0, OFS_IRQ_MASK, 0, 0);
    bus(0, OFS_SS_A, 0, 0);
    final_report();
  end
endmodule : usf_regs_bench
`default_nettype wire

/* sim/usf_regs_chk.sv */
// Purpose: Port checks on the usf register bank.
// Assumes: One clock; helpers mirror the debounce and mask bits.
// Notes: Threshold and voltage mirrors lag one cycle, as the flag does.
`timescale 1ns/1ps
`default_nettype none
module usf_regs_chk
  import usf_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = 8
)
(
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR_STB,
  input wire logic        RD_STB,
  input wire logic [7:0]  RDATA,
  input wire logic [7:0]  CHAN_B_SENSED_VOLTAGE,
  input wire logic        CHAN_B_UNDERVOLT_FLAG,
  input wire logic [13:0] CHAN_B_UV_THRESHOLD,
  input wire logic [1:0]  CHAN_A_RAMP_SEL,
  input wire logic [1:0]  CHAN_B_RAMP_SEL,
  input wire logic [15:0] CHAN_A_RAMP_TIME_US,
  input wire logic [15:0] CHAN_B_RAMP_TIME_US,
  input wire logic        IRQ
);
  logic [6:0]  prev_v;  // Voltage MSBs of the previous cycle.
  logic        deb_on;  // Copy of the debounce select bit.
  logic [1:0]  mask_q;  // Copy of the interrupt mask.
  int unsigned run;     // Cycles the lagged comparison has held.
  logic        lag_cmp; // Comparison that the flag should now show.
  int unsigned need;    // Extra held cycles the debounce demands.
  logic        deb_lag; // Debounce bit as the flag logic last used it.
  assign lag_cmp = CHAN_B_UV_THRESHOLD > 14'(prev_v) * 14'h7d;
  assign need    = deb_lag ? DEBOUNCE_CYCLES - 1 : 0;

  // Mirrors follow the bus, so a missed decode shows as a flag or interrupt mismatch.
  always_ff @(posedge CORE_CLK)
  begin
    prev_v <= CHAN_B_SENSED_VOLTAGE[7:1];
    run    <= lag_cmp ? run + 1 : 0;
    deb_lag <= deb_on;
    if (!RST_N)
    begin
      deb_on <= 1'b0;
      mask_q <= 2'h0;
    end
    else if (WR_STB && ADDR == OFS_UV_B_SET)
      deb_on <= WDATA[7];
    else if (WR_STB && ADDR == OFS_IRQ_MASK)
      mask_q <= WDATA[1:0];
  end

  function automatic logic [15:0] rtime(input logic [1:0] s);
    return s[1] ? (s[0] ? RAMP_US_3 : RAMP_US_2)
                : (s[0] ? RAMP_US_1 : RAMP_US_0);
  endfunction : rtime

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_rdata_idle: assert property (!RD_STB |=> RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  a_flag_cause: assert property (
    CHAN_B_UNDERVOLT_FLAG == (lag_cmp && run >= need))
    else $error("undervoltage flag disagrees with held comparison");
  a_zero_clear: assert property (
    CHAN_B_UV_THRESHOLD == 14'h0 |-> !CHAN_B_UNDERVOLT_FLAG)
    else $error("flag set with zero threshold");
  a_thr_step: assert property (WR_STB && ADDR == OFS_UV_B_SET |->
    ##2 CHAN_B_UV_THRESHOLD == 14'($past(WDATA[6:0], 2)) * 14'h7d)
    else $error("threshold output not code times step");
  a_sel_follow: assert property (WR_STB && ADDR == OFS_SS_A |->
    ##2 CHAN_A_RAMP_SEL == $past(WDATA[1:0], 2))
    else $error("ramp select does not follow low bits");
  a_ramp_a: assert property (
    CHAN_A_RAMP_TIME_US == rtime(CHAN_A_RAMP_SEL))
    else $error("channel A ramp time wrong for its code");
  a_ramp_b: assert property (
    CHAN_B_RAMP_TIME_US == rtime(CHAN_B_RAMP_SEL))
    else $error("channel B ramp time wrong for its code");
  a_irq_rise: assert property ($rose(CHAN_B_UNDERVOLT_FLAG) |=>
    IRQ || !mask_q[EV_RISE_BIT])
    else $error("enabled flag rise did not raise the interrupt");
  a_irq_fall: assert property ($fell(CHAN_B_UNDERVOLT_FLAG) |=>
    IRQ || !mask_q[EV_FALL_BIT])
    else $error("enabled flag fall did not raise the interrupt");
  a_irq_masked: assert property (mask_q == 2'h0 && !WR_STB |=> !IRQ)
    else $error("interrupt high with every source masked");

  c_deb_flag: cover property ($rose(CHAN_B_UNDERVOLT_FLAG) && deb_on);
  c_irq_rise: cover property ($rose(IRQ));
  c_read_data: cover property (RD_STB ##1 RDATA != 8'h00);
endmodule : usf_regs_chk

bind usf_regs usf_regs_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
  .CORE_CLK, .RST_N, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
  .CHAN_B_SENSED_VOLTAGE, .CHAN_B_UNDERVOLT_FLAG, .CHAN_B_UV_THRESHOLD,
  .CHAN_A_RAMP_SEL, .CHAN_B_RAMP_SEL, .CHAN_A_RAMP_TIME_US,
  .CHAN_B_RAMP_TIME_US, .IRQ);
`default_nettype wire
